// *** verilog/ebh_pkg.sv ***
// Shared types and constants for the external bus handshake and region select block
package ebh_pkg;
  // ==========================================================================
  // Widths and counts
  // ==========================================================================
  localparam int ADDR_W = 25;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int REGION_CNT = 4;
  localparam int BEAT_W = 3;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 3'h1;

  // ==========================================================================
  // Reset values of the bus pins and of the region windows
  // ==========================================================================
  localparam logic [BE_W-1:0] BE_IDLE = 4'hF;
  localparam logic [REGION_CNT-1:0] SEL_IDLE = 4'hF;
  localparam logic [ADDR_W-1:0] RANGE_RESET_BASE = 25'h1FFFFFF;
  localparam logic [ADDR_W-1:0] RANGE_RESET_LIMIT = 25'h0000000;

  // ==========================================================================
  // Types
  // ==========================================================================
  // One programmed region: inclusive word address window
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] limit;
  } ebh_range_t;

  // Access request from the core side
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be;
    logic [BEAT_W-1:0] beats;
  } ebh_req_t;

  // Completion report toward the core side
  typedef struct packed {
    logic done;
    logic fault;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } ebh_rsp_t;

  typedef enum logic [1:0] {
    EBH_IDLE,
    EBH_BEAT,
    EBH_END
  } ebh_state_t;
endpackage : ebh_pkg

// *** verilog/ebh_region_decode.sv ***
// Address decoder that turns one address into active-high region hit bits
`timescale 1ns/1ps
module ebh_region_decode #(
  parameter int N = ebh_pkg::REGION_CNT
) (
  input wire logic [ebh_pkg::ADDR_W-1:0] addr_i, // Word address under test
  input wire ebh_pkg::ebh_range_t [N-1:0] range_i, // Programmed windows
  output logic [N-1:0] hit_o // One bit per matching window, active high
);
  import ebh_pkg::*;

  // Elaboration check: a decoder with no windows cannot drive any select
  if (N < 1) begin : g_bad_n
    $error("ebh_region_decode needs at least one region");
  end

  // Window test, inclusive at both ends; an empty window (base > limit) never hits
  function automatic logic in_range(input logic [ADDR_W-1:0] a, input ebh_range_t r);
    in_range = (a >= r.base) && (a <= r.limit);
  endfunction : in_range

  genvar g;
  for (g = 0; g < N; g++) begin : g_hit
    assign hit_o[g] = in_range(addr_i, range_i[g]);
  end
endmodule : ebh_region_decode

// *** verilog/ebh_bus_master.sv ***
// External bus master: strobes, handshake, bus fault and region chip selects
// How it works
// RULE_01 - Bus fault input ends current access and reports a bus-error exception.
// RULE_02 - External device asserts acknowledge for each read data beat it supplies.
// RULE_03 - Read data captured on the clock edge where acknowledge is seen.
// RULE_04 - External device acknowledges a write only after capturing the data.
// RULE_05 - Write acknowledge completes that beat and, on the last, the transaction.
// RULE_06 - Low reset input holds everything in its reset state.
// RULE_07 - System clock is driven out on its own pin as bus reference; the code drives out mclk_i divided by two instead.
// RULE_08 - Each region select two to five drops low for addresses in its range.
// RULE_09 - Bus-start output pulses low for exactly one cycle per access.
// RULE_10 - Final-beat output low while the last data item transfers.
// RULE_11 - Read strobe low through reads, write strobe low through writes.
// RULE_12 - Multi-beat indicator low for any burst access.
// RULE_13 - No region select outside ranges or while the bus is idle.
`timescale 1ns/1ps
module ebh_bus_master #(
  parameter int MAX_BEATS = 4
) (
  input wire logic mclk_i, // Master clock, 25 MHz
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic req_valid_i, // Core wants an access
  input wire ebh_pkg::ebh_req_t req_i, // Access description
  input wire logic [ebh_pkg::DATA_W-1:0] wdata_i, // Write data for the current beat
  output logic req_ready_o, // Request taken on the previous clock edge
  output logic wdata_take_o, // Write beat accepted by the device on the previous clock edge
  output ebh_pkg::ebh_rsp_t rsp_o, // Read beats and completion report
  output logic bus_error_exc_o, // One-cycle bus-error exception pulse
  input wire ebh_pkg::ebh_range_t [ebh_pkg::REGION_CNT-1:0] region_range_cfg_i, // Windows 2..5
  output logic bus_ref_clock_o, // Bus reference clock pin
  output logic [ebh_pkg::ADDR_W-1:0] addr_o, // Address pins A[26:2]
  output logic [ebh_pkg::BE_W-1:0] be_n_o, // Byte enables, active low
  input wire logic [ebh_pkg::DATA_W-1:0] data_i, // Data bus, in
  output logic [ebh_pkg::DATA_W-1:0] data_o, // Data bus, out
  output logic data_oe_o, // Data bus drive enable
  output logic rd_n_o, // Read strobe
  output logic wr_n_o, // Write strobe
  output logic last_n_o, // Final beat
  output logic access_begin_n_o, // Start of access pulse
  output logic burst_n_o, // Multi-beat indicator
  input wire logic ack_n_i, // Transfer acknowledge from device
  input wire logic bus_fault_n_i, // Bus error from device
  output logic region_select_2_n_o, // Region 2 select
  output logic region_select_3_n_o, // Region 3 select
  output logic region_select_4_n_o, // Region 4 select
  output logic region_select_5_n_o // Region 5 select
);
  import ebh_pkg::*;

  // Elaboration check: the beat counter cannot hold more than its own width allows
  if (MAX_BEATS < 1 || MAX_BEATS > (1 << BEAT_W) - 1) begin : g_bad_beats
    $error("MAX_BEATS out of range");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  ebh_state_t state_ff, nxt_state;
  logic [BEAT_W-1:0] left_ff, nxt_left;
  logic write_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [BE_W-1:0] be_n_ff;
  logic [DATA_W-1:0] dout_ff;
  logic oe_ff, rd_n_ff, wr_n_ff, last_n_ff, begin_n_ff, burst_n_ff;
  logic [REGION_CNT-1:0] sel_n_ff;
  logic ready_ff, take_ff, exc_ff;
  ebh_rsp_t rsp_ff;
  logic clk_div_ff;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  wire logic [REGION_CNT-1:0] hit;
  wire logic start = (state_ff == EBH_IDLE) && req_valid_i;
  wire logic in_beat = (state_ff == EBH_BEAT);
  wire logic acked = in_beat && !ack_n_i;
  wire logic faulted = in_beat && !bus_fault_n_i;
  wire logic final_ack = acked && (left_ff == BEAT_ONE);
  // Clamp a zero or oversized beat count so the burst length stays bounded
  wire logic [BEAT_W-1:0] req_beats = (req_i.beats == '0) ? BEAT_ONE :
      (req_i.beats > BEAT_W'(MAX_BEATS)) ? BEAT_W'(MAX_BEATS) : req_i.beats;

  // Decode on the request address so the selects come up with the strobe
  ebh_region_decode #(.N(REGION_CNT)) u_decode (
    .addr_i(req_i.addr),
    .range_i(region_range_cfg_i),
    .hit_o(hit)
  );

  // Sequencer: fault takes priority over acknowledge in the same cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_left = left_ff;
    case (state_ff)
      EBH_IDLE: begin
        if (start) begin
          nxt_state = EBH_BEAT;
          nxt_left = req_beats;
        end
      end
      EBH_BEAT: begin
        if (faulted || final_ack) begin // RULE_01 RULE_05
          nxt_state = EBH_END;
        end else if (acked) begin
          nxt_left = left_ff - BEAT_ONE;
        end
      end
      EBH_END: nxt_state = EBH_IDLE; // Two idle bus cycles (END, then IDLE) between accesses
      default: nxt_state = EBH_IDLE;
    endcase
  end

  // Control state
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin // RULE_06
      state_ff <= EBH_IDLE;
      left_ff <= '0;
      write_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      left_ff <= nxt_left;
      if (start) write_ff <= req_i.write;
    end
  end

  // Bus reference clock: half the master rate, every bus edge on a master edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) clk_div_ff <= 1'b0;
    else clk_div_ff <= ~clk_div_ff; // RULE_07
  end

  // Address and byte lanes held for the whole access; write data reloaded at start and on each ack
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_ff <= '0;
      be_n_ff <= BE_IDLE;
      dout_ff <= '0;
      oe_ff <= 1'b0;
    end else begin
      if (start) addr_ff <= req_i.addr;
      if (start) be_n_ff <= ~req_i.be;
      if (start || acked) dout_ff <= wdata_i; // Next beat data follows each ack
      oe_ff <= start ? req_i.write : (oe_ff && !(faulted || final_ack));
    end
  end

  // Strobes: read or write strobe, burst flag and selects drop with the start pulse, final beat may drop later; all rise after the end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      last_n_ff <= 1'b1;
      begin_n_ff <= 1'b1;
      burst_n_ff <= 1'b1;
      sel_n_ff <= SEL_IDLE;
    end else if (start) begin
      rd_n_ff <= req_i.write; // RULE_11
      wr_n_ff <= !req_i.write; // RULE_11
      begin_n_ff <= 1'b0; // RULE_09
      last_n_ff <= !(req_beats == BEAT_ONE); // RULE_10
      burst_n_ff <= (req_beats == BEAT_ONE); // RULE_12
      sel_n_ff <= ~hit; // RULE_08 RULE_13
    end else begin
      begin_n_ff <= 1'b1; // RULE_09
      if (faulted || final_ack) begin
        rd_n_ff <= 1'b1;
        wr_n_ff <= 1'b1;
        last_n_ff <= 1'b1;
        burst_n_ff <= 1'b1;
        sel_n_ff <= SEL_IDLE; // RULE_13
      end else if (acked && left_ff == BEAT_W'(2)) begin
        last_n_ff <= 1'b0; // RULE_10
      end
    end
  end

  // Core-side answers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_ff <= 1'b0;
      take_ff <= 1'b0;
      exc_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      ready_ff <= start;
      take_ff <= acked && write_ff && !faulted; // RULE_05
      exc_ff <= faulted; // RULE_01
      rsp_ff.done <= faulted || final_ack;
      rsp_ff.fault <= faulted;
      rsp_ff.rvalid <= acked && !write_ff && !faulted; // RULE_02
      if (acked && !write_ff) rsp_ff.rdata <= data_i; // RULE_03
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  // ==========================================================================
  assign req_ready_o = ready_ff;
  assign wdata_take_o = take_ff;
  assign rsp_o = rsp_ff;
  assign bus_error_exc_o = exc_ff;
  assign bus_ref_clock_o = clk_div_ff;
  assign addr_o = addr_ff;
  assign be_n_o = be_n_ff;
  assign data_o = dout_ff;
  assign data_oe_o = oe_ff;
  assign rd_n_o = rd_n_ff;
  assign wr_n_o = wr_n_ff;
  assign last_n_o = last_n_ff;
  assign access_begin_n_o = begin_n_ff;
  assign burst_n_o = burst_n_ff;
  assign region_select_2_n_o = sel_n_ff[0];
  assign region_select_3_n_o = sel_n_ff[1];
  assign region_select_4_n_o = sel_n_ff[2];
  assign region_select_5_n_o = sel_n_ff[3];
endmodule : ebh_bus_master

// *** dv/ebh_bus_checker.sv ***
// Concurrent checks on the bus master pins
`timescale 1ns/1ps
module ebh_bus_checker (
  input wire logic mclk_i, // Clock
  input wire logic reset_n_i, // Reset
  input wire ebh_pkg::ebh_req_t req_i, // Request
  input wire logic ack_n_i, // Ack
  input wire logic bus_fault_n_i, // Fault
  input wire logic req_ready_o, // Taken
  input wire ebh_pkg::ebh_rsp_t rsp_o, // Report
  input wire logic bus_error_exc_o, // Exception
  input wire logic bus_ref_clock_o, // Bus clock
  input wire logic rd_n_o, // Read
  input wire logic wr_n_o, // Write
  input wire logic last_n_o, // Final beat
  input wire logic access_begin_n_o, // Begin
  input wire logic burst_n_o, // Burst
  input wire logic region_select_2_n_o, // Region 2
  input wire logic region_select_3_n_o, // Region 3
  input wire logic region_select_4_n_o, // Region 4
  input wire logic region_select_5_n_o // Region 5
);
  // ==========================================
  // Properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire idle = rd_n_o && wr_n_o;
  property p_begin; !access_begin_n_o |-> req_ready_o ##1 access_begin_n_o; endproperty
  a_begin: assert property (p_begin) else $error("begin pulse");
  property p_dir;
    req_ready_o |-> rd_n_o == $past(req_i.write) && wr_n_o != $past(req_i.write);
  endproperty
  a_dir: assert property (p_dir) else $error("strobe direction");
  property p_burst; req_ready_o |-> burst_n_o == ($past(req_i.beats) <= 3'h1); endproperty
  a_burst: assert property (p_burst) else $error("burst flag");
  property p_last; req_ready_o && $past(req_i.beats) <= 3'h1 |-> !last_n_o; endproperty
  a_last: assert property (p_last) else $error("single beat final");
  property p_fault;
    !bus_fault_n_i && !idle |=> bus_error_exc_o && rsp_o.fault && rd_n_o && wr_n_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault end");
  property p_rack; !ack_n_i && bus_fault_n_i && !rd_n_o |=> rsp_o.rvalid; endproperty
  a_rack: assert property (p_rack) else $error("read capture");
  property p_wack;
    !ack_n_i && bus_fault_n_i && !wr_n_o && !last_n_o |=> wr_n_o && rsp_o.done;
  endproperty
  a_wack: assert property (p_wack) else $error("write end");
  property p_sel;
    idle |-> region_select_2_n_o && region_select_3_n_o && region_select_4_n_o &&
      region_select_5_n_o;
  endproperty
  a_sel: assert property (p_sel) else $error("select while idle");
  // Out of reset the bus clock must toggle on every master edge, not merely keep toggling
  property p_clk; $past(reset_n_i) |-> bus_ref_clock_o != $past(bus_ref_clock_o); endproperty
  a_clk: assert property (p_clk) else $error("bus clock stalled");
  c_rd: cover property (rsp_o.rvalid);
  c_flt: cover property (bus_error_exc_o);
  c_wburst: cover property (!burst_n_o && !wr_n_o);
endmodule : ebh_bus_checker

bind ebh_bus_master ebh_bus_checker u_chk (.*);

// *** dv/ebh_dev_model.sv ***
// Behavioural bus device answering the master
`timescale 1ns/1ps
module ebh_dev_model (
  input wire logic mclk_i, // Clock
  input wire logic rd_n_i, // Read strobe
  input wire logic wr_n_i, // Write strobe
  input wire logic [31:0] wdata_i, // Master data
  input wire logic [3:0] wait_i, // Wait per beat
  input wire logic fault_i, // Answer with fault
  output logic ack_n_o, // Acknowledge
  output logic fault_n_o, // Bus fault
  output logic [31:0] rdata_o, // Device data
  output logic [31:0] cap_o, // Last write word
  output logic [2:0] bn_o // Beats done
);
  // ==========================================
  // Beat handshake
  logic [3:0] cnt = 4'h0;
  initial {ack_n_o, fault_n_o, bn_o, cap_o} = {2'b11, 35'h0};
  // Released bus shows the inverse word so stale data never matches
  assign rdata_o = {32{ack_n_o}} ^ (32'hBEEF0000 + 32'(bn_o));
  always @(posedge mclk_i) begin
    if (rd_n_i && wr_n_i) begin
      {ack_n_o, fault_n_o, cnt, bn_o} <= {2'b11, 7'h0};
    end else if (!ack_n_o || !fault_n_o) begin
      {ack_n_o, fault_n_o, cnt} <= {2'b11, 4'h0};
      bn_o <= bn_o + 3'h1;
    end else if (cnt == wait_i) begin
      // Word is taken on the same edge the acknowledge goes out
      ack_n_o <= fault_i;
      fault_n_o <= !fault_i;
      cap_o <= wdata_i;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : ebh_dev_model

// *** dv/tb.sv ***
// Self-checking bench for the external bus master
`timescale 1ns/1ps
module tb;
  import ebh_pkg::*;
  // ==========================================
  // Signals
  logic mclk_i = 0, reset_n_i = 0, req_valid_i = 0, fault = 0, lst0;
  logic req_ready_o, wdata_take_o, bus_error_exc_o, bus_ref_clock_o, data_oe_o;
  logic rd_n_o, wr_n_o, last_n_o, access_begin_n_o, burst_n_o, ack_n_i, bus_fault_n_i;
  logic region_select_2_n_o, region_select_3_n_o, region_select_4_n_o, region_select_5_n_o;
  logic [31:0] data_i, data_o, wdata_i, cap;
  logic [24:0] addr_o;
  logic [3:0] be_n_o, wt = 0;
  logic [2:0] bn;
  ebh_req_t req_i = '0;
  ebh_rsp_t rsp_o;
  ebh_range_t [REGION_CNT-1:0] region_range_cfg_i;
  int miscompares = 0, tests_run = 0, nb, n2, n3, n4, n5, nbur, nrv, ntk, nexc, fin;
  // Three live windows, one empty one (base above limit)
  assign region_range_cfg_i = '{'{25'h1, 25'h0}, '{25'h400, 25'h4FF},
    '{25'h200, 25'h2FF}, '{25'h100, 25'h1FF}};
  // Next beat word is ready at the acknowledge edge
  assign wdata_i = 32'hC0DE0000 + 32'(bn) + 32'(!ack_n_i);
  ebh_bus_master #(.MAX_BEATS(4)) DUT (.*);
  ebh_dev_model u_dev (.mclk_i, .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .wdata_i(data_o),
    .wait_i(wt), .fault_i(fault), .ack_n_o(ack_n_i), .fault_n_o(bus_fault_n_i),
    .rdata_o(data_i), .cap_o(cap), .bn_o(bn));
  initial forever #20 mclk_i = !mclk_i;
  // ==========================================
  // Helpers
  task automatic final_report();
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input bit c);
    tests_run++;
    if (!c) begin
      miscompares++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask : chk
  // One access, watched cycle by cycle until done or fault
  task automatic run(input logic w, input logic [24:0] a, input logic [2:0] n,
    input logic [3:0] wv, input logic f);
    {nb, n2, n3, n4, n5, nbur, nrv, ntk, nexc, fin} = '0;
    @(posedge mclk_i);
    req_i <= '{w, a, 4'hF, n};
    req_valid_i <= 1'b1;
    wt <= wv;
    fault <= f;
    for (int k = 0; k < 80 && fin == 0; k++) begin
      @(negedge mclk_i);
      if (access_begin_n_o === 1'b0) begin
        {nb, lst0} = {nb + 1, last_n_o};
        chk({addr_o, be_n_o, data_oe_o, rd_n_o, wr_n_o} === {a, 4'h0, w, w, !w});
      end
      n2 += int'(region_select_2_n_o === 1'b0);
      n3 += int'(region_select_3_n_o === 1'b0);
      n4 += int'(region_select_4_n_o === 1'b0);
      n5 += int'(region_select_5_n_o === 1'b0);
      nbur += int'(burst_n_o === 1'b0);
      nexc += int'(bus_error_exc_o === 1'b1);
      if (rsp_o.rvalid === 1'b1) chk(rsp_o.rdata === 32'hBEEF0000 + nrv++);
      if (wdata_take_o === 1'b1) chk(cap === 32'hC0DE0000 + ntk++);
      fin = int'(rsp_o.done === 1'b1 || rsp_o.fault === 1'b1);
      if (req_ready_o === 1'b1) @(posedge mclk_i) req_valid_i <= 1'b0;
    end
    if (fin == 0) chk(1'b0);
    if (fin == 0) final_report();
  endtask : run
  // ==========================================
  // Scenarios
  task automatic sc_reset();
    logic b;
    @(negedge mclk_i);
    chk({rd_n_o, wr_n_o, access_begin_n_o, region_select_2_n_o, data_oe_o,
      bus_ref_clock_o} === 6'b111100);
    @(posedge mclk_i) reset_n_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    b = bus_ref_clock_o;
    @(negedge mclk_i);
    chk(bus_ref_clock_o === !b);
  endtask : sc_reset
  task automatic sc_read1();
    run(1'b0, 25'h100, 3'h1, 4'h0, 1'b0);
    chk(nb == 1 && nrv == 1);
    chk(n2 > 0 && n3 == 0);
    chk(nbur == 0 && lst0 === 1'b0);
  endtask : sc_read1
  task automatic sc_burst();
    run(1'b0, 25'h1FF, 3'h4, 4'h3, 1'b0);
    chk(nrv == 4 && n2 > 0 && nb == 1);
    chk(nbur > 0 && lst0 === 1'b1);
  endtask : sc_burst
  task automatic sc_write();
    run(1'b1, 25'h200, 3'h3, 4'h1, 1'b0);
    chk(ntk == 3 && nrv == 0);
    chk(n3 > 0 && n2 == 0);
  endtask : sc_write
  task automatic sc_miss();
    run(1'b0, 25'h0FF, 3'h1, 4'h0, 1'b0);
    chk(n2 + n3 + n4 + n5 == 0);
    run(1'b0, 25'h300, 3'h1, 4'h0, 1'b0);
    chk(n2 + n3 + n4 + n5 == 0);
  endtask : sc_miss
  // Top end of the region 4 window, two-beat read
  task automatic sc_high();
    run(1'b0, 25'h4FF, 3'h2, 4'h0, 1'b0);
    chk(n4 > 0 && n2 + n3 + n5 == 0 && nrv == 2);
  endtask : sc_high
  task automatic sc_fault();
    run(1'b0, 25'h100, 3'h2, 4'h2, 1'b1);
    chk(nexc == 1 && nrv == 0);
  endtask : sc_fault
  initial begin
    repeat (3) @(posedge mclk_i);
    sc_reset();
    sc_read1();
    sc_burst();
    sc_write();
    sc_miss();
    sc_high();
    sc_fault();
    sc_read1();
    final_report();
  end
endmodule : tb
